// File: core/pdp_pkg.sv
// package of register map, field positions and timing for the parallel data port
package pdp_pkg;
   localparam logic [31:0] PDP_CTRL_STAT_OFS = 32'h0000_00FA;
   localparam logic [31:0] PDP_DATA_OFS = 32'h0000_00FD;
   localparam logic [31:0] PDP_IRQ_STAT_OFS = 32'h0000_0100;
   localparam logic [31:0] PDP_IRQ_MASK_OFS = 32'h0000_0104;
   localparam int PDP_OFS_IDX_SCALE = 4;
   localparam int PDP_ACCEPT_BIT = 2;
   localparam int PDP_AVAIL_BIT = 1;
   localparam int PDP_USEL_BIT = 4;
   localparam int PDP_USEL_HI_BIT = 5;
   localparam int PDP_IEN_BIT = 6;
   localparam int PDP_OEN_BIT = 7;
   localparam int PDP_IRQ_OUT_BIT = 0;
   localparam int PDP_IRQ_IN_BIT = 1;
   localparam logic [7:0] PDP_CTRL_RESET = 8'h00;
   localparam logic [1:0] PDP_IRQ_MASK_RESET = 2'h0;
   localparam int PDP_CLK_MHZ = 125;
   localparam int PDP_STROBE_NS = 80;
   localparam int PDP_STROBE_CYC = (PDP_STROBE_NS * PDP_CLK_MHZ + 999) / 1000;
   localparam logic [1:0] PDP_RESP_OKAY = 2'b00;
   localparam logic [1:0] PDP_RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {PDP_HS_IDLE, PDP_HS_OUT, PDP_HS_IN} pdp_hs_t;
endpackage

// File: core/pdp_top.sv
// parallel byte port with axi4-lite register slave and interrupt
`timescale 1ns/1ns
`default_nettype none
module pdp_top
   import pdp_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [7:0] par_out_o,
   input wire logic [7:0] par_in_i,
   output logic out_strobe_n_o,
   input wire logic output_accept_ready_n_i,
   output logic in_ack_n_o,
   input wire logic input_byte_ready_n_i,
   output logic unit_select_bit_o,
   output logic unit_select_hi_o,
   output logic in_enable_n_o,
   output logic out_enable_n_o,
   output logic irq_o
);
   function automatic logic addr_is(input logic [31:0] a, input logic [31:0] ofs);
      addr_is = (a[31:2] == 30'(ofs * PDP_OFS_IDX_SCALE >> 2));
   endfunction

   // true for the four decoded registers; anything else answers with a slave error
   function automatic logic addr_mapped(input logic [31:0] a);
      addr_mapped = addr_is(a, PDP_CTRL_STAT_OFS) || addr_is(a, PDP_DATA_OFS)
         || addr_is(a, PDP_IRQ_STAT_OFS) || addr_is(a, PDP_IRQ_MASK_OFS);
   endfunction

   logic [31:0] awaddr_q;
   logic aw_held_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_held_q;
   logic [7:0] ctrl_q;
   logic [7:0] out_byte_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic [7:0] strobe_cnt_q;
   pdp_hs_t hs_q;
   logic wr_fire;
   logic rd_fire;
   logic data_wr;
   logic data_rd;
   logic stat_rd;
   logic accept_prev_q;
   logic avail_prev_q;
   logic [31:0] rdata_d;
   logic rd_ok;

   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign data_wr = wr_fire && addr_is(awaddr_q, PDP_DATA_OFS) && wstrb_q[0];
   assign data_rd = rd_fire && addr_is(s_axi_araddr, PDP_DATA_OFS);
   assign stat_rd = rd_fire && addr_is(s_axi_araddr, PDP_IRQ_STAT_OFS);

   // write address and data may arrive in either order; each is parked until both are here
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         awaddr_q <= 32'h0000_0000;
         aw_held_q <= 1'b0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_held_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         w_held_q <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_q && !s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_held_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_bvalid <= 1'b0;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_bresp <= PDP_RESP_OKAY;
      end else if (wr_fire) begin
         if (addr_mapped(awaddr_q)) begin
            s_axi_bresp <= PDP_RESP_OKAY;
         end else begin
            s_axi_bresp <= PDP_RESP_SLVERR;
         end
      end
   end

   // control bits steer the connector's select and enable lines
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_q <= PDP_CTRL_RESET;
      end else if (wr_fire && wstrb_q[0]) begin
         if (addr_is(awaddr_q, PDP_CTRL_STAT_OFS)) begin
            ctrl_q <= wdata_q[7:0];
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_mask_q <= PDP_IRQ_MASK_RESET;
      end else if (wr_fire && wstrb_q[0]) begin
         if (addr_is(awaddr_q, PDP_IRQ_MASK_OFS)) begin
            irq_mask_q <= wdata_q[1:0];
         end
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      rd_ok = 1'b1;
      if (addr_is(s_axi_araddr, PDP_CTRL_STAT_OFS)) begin
         rdata_d[7:0] = ctrl_q;
         rdata_d[PDP_ACCEPT_BIT] = output_accept_ready_n_i;
         rdata_d[PDP_AVAIL_BIT] = input_byte_ready_n_i;
      end else if (addr_is(s_axi_araddr, PDP_DATA_OFS)) begin
         rdata_d[7:0] = par_in_i;
      end else if (addr_is(s_axi_araddr, PDP_IRQ_STAT_OFS)) begin
         rdata_d[1:0] = irq_stat_q;
      end else if (addr_is(s_axi_araddr, PDP_IRQ_MASK_OFS)) begin
         rdata_d[1:0] = irq_mask_q;
      end else begin
         rd_ok = 1'b0;
      end
   end

   // one read at a time: arready stays low until the answer has been taken
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_arready <= 1'b0;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_rvalid <= 1'b0;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= PDP_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rdata <= rdata_d;
         s_axi_rresp <= rd_ok ? PDP_RESP_OKAY : PDP_RESP_SLVERR;
      end
   end

   // the byte follows every data write, even one landing mid-pulse; the pulse is not restarted
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_byte_q <= 8'h00;
      end else if (data_wr) begin
         out_byte_q <= wdata_q[7:0];
      end
   end

   // handshake pulses: out strobe after a data write, in ack after a data read
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hs_q <= PDP_HS_IDLE;
         strobe_cnt_q <= 8'h00;
      end else begin
         case (hs_q)
            PDP_HS_IDLE: begin
               if (data_wr) begin
                  hs_q <= PDP_HS_OUT;
                  strobe_cnt_q <= 8'(PDP_STROBE_CYC);
               end else if (data_rd) begin
                  hs_q <= PDP_HS_IN;
                  strobe_cnt_q <= 8'(PDP_STROBE_CYC);
               end
            end
            PDP_HS_OUT, PDP_HS_IN: begin
               if (strobe_cnt_q == 8'h01) begin
                  hs_q <= PDP_HS_IDLE;
               end
               strobe_cnt_q <= strobe_cnt_q - 8'h01;
            end
            default: hs_q <= PDP_HS_IDLE;
         endcase
      end
   end

   // connector outputs are registered so no decode glitch reaches the cable
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         par_out_o <= 8'h00;
      end else begin
         par_out_o <= out_byte_q;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_strobe_n_o <= 1'b1;
      end else begin
         out_strobe_n_o <= (hs_q != PDP_HS_OUT);
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         in_ack_n_o <= 1'b1;
      end else begin
         in_ack_n_o <= (hs_q != PDP_HS_IN);
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         unit_select_bit_o <= 1'b0;
      end else begin
         unit_select_bit_o <= ctrl_q[PDP_USEL_BIT];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         unit_select_hi_o <= 1'b0;
      end else begin
         unit_select_hi_o <= ctrl_q[PDP_USEL_HI_BIT];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         in_enable_n_o <= 1'b1;
      end else begin
         in_enable_n_o <= !ctrl_q[PDP_IEN_BIT];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_enable_n_o <= 1'b1;
      end else begin
         out_enable_n_o <= !ctrl_q[PDP_OEN_BIT];
      end
   end

   // previous flags reset to the idle high level so release of reset makes no false edge
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         accept_prev_q <= 1'b1;
         avail_prev_q <= 1'b1;
      end else begin
         accept_prev_q <= output_accept_ready_n_i;
         avail_prev_q <= input_byte_ready_n_i;
      end
   end

   // sticky events on the falling edge of each ready flag; a new event beats the read clear
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_stat_q <= 2'h0;
      end else begin
         irq_stat_q <= (stat_rd ? 2'h0 : irq_stat_q)
            | {avail_prev_q && !input_byte_ready_n_i, accept_prev_q && !output_accept_ready_n_i};
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_q & irq_mask_q);
      end
   end
endmodule // pdp_top
`default_nettype wire

// File: tb/pdp_peripheral.sv
// behavioural peripheral on the parallel connector
`timescale 1ns/1ns
`default_nettype none
module pdp_peripheral (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [7:0] byte_i,
   input wire logic strobe_n_i,
   input wire logic ack_n_i,
   input wire logic sel_i,
   input wire logic ien_n_i,
   input wire logic [3:0] delay_i,
   input wire logic load_i,
   input wire logic [7:0] next_i,
   output logic accept_n_o,
   output logic ready_n_o,
   output logic [7:0] data_o,
   output logic [7:0] got_o
);
   logic busy_q, idle_q, stb_q;
   logic [3:0] cnt_q;
   logic [7:0] held_q;
   // flags stay inactive while another unit is selected
   assign accept_n_o = busy_q | ~sel_i;
   assign ready_n_o = idle_q | ~sel_i;
   // disabled drivers show the inverse so a stale byte cannot pass
   assign data_o = ien_n_i ? ~held_q : held_q;
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_q <= 1'h0;
         idle_q <= 1'h1;
         stb_q <= 1'h1;
         cnt_q <= 4'h0;
         held_q <= 8'h00;
         got_o <= 8'h00;
      end else begin
         stb_q <= strobe_n_i;
         if (strobe_n_i && !stb_q) begin
            got_o <= byte_i;
            busy_q <= 1'h1;
            cnt_q <= delay_i;
         end else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
         else busy_q <= 1'h0;
         if (load_i) begin
            held_q <= next_i;
            idle_q <= 1'h0;
         end else if (!ack_n_i) idle_q <= 1'h1;
      end
   end
endmodule // pdp_peripheral
`default_nettype wire

// File: tb/pdp_properties.sv
// checker of the parallel port's bus and handshake timing
`timescale 1ns/1ns
`default_nettype none
module pdp_checker (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic out_strobe_n_o,
   input wire logic in_ack_n_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   a_strobe_width: assert property ($fell(out_strobe_n_o) |-> ##9 !out_strobe_n_o ##1 out_strobe_n_o)
      else $error("output strobe width wrong");
   a_ack_width: assert property ($fell(in_ack_n_o) |-> ##9 !in_ack_n_o ##1 in_ack_n_o)
      else $error("input ack width wrong");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped");
   a_aw_pulse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("awready held after take");
   a_ar_pulse: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
      else $error("arready held after take");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_strobe: cover property ($fell(out_strobe_n_o));
   c_irq: cover property ($rose(irq_o));
endmodule // pdp_checker
bind pdp_top pdp_checker u_chk (.clock_i, .rstn_i, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .out_strobe_n_o, .in_ack_n_o, .irq_o);
`default_nettype wire

// File: tb/pdp_top_bench.sv
// self-checking bench of the parallel port
`timescale 1ns/1ns
`default_nettype none
module pdp_top_bench;
   import pdp_pkg::*;
   logic clock_i = 0, rstn_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, load = 0;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 0, dly = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [7:0] par_out_o, par_in_i, nxt = 0, got, b;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
   logic out_strobe_n_o, output_accept_ready_n_i, in_ack_n_o, input_byte_ready_n_i;
   logic unit_select_bit_o, unit_select_hi_o, in_enable_n_o, out_enable_n_o;
   int seed = 48, error_cnt = 0, tests_run = 0, cyc = 0;
   localparam logic [31:0] CTL = 32'(PDP_CTRL_STAT_OFS * PDP_OFS_IDX_SCALE);
   localparam logic [31:0] DAT = 32'(PDP_DATA_OFS * PDP_OFS_IDX_SCALE);
   localparam logic [31:0] STA = 32'(PDP_IRQ_STAT_OFS * PDP_OFS_IDX_SCALE);
   localparam logic [31:0] MSK = 32'(PDP_IRQ_MASK_OFS * PDP_OFS_IDX_SCALE);
   pdp_top u_dut (.clock_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .par_out_o, .par_in_i, .out_strobe_n_o,
      .output_accept_ready_n_i, .in_ack_n_o, .input_byte_ready_n_i, .unit_select_bit_o,
      .unit_select_hi_o, .in_enable_n_o, .out_enable_n_o, .irq_o);
   pdp_peripheral u_per (.clock_i, .rstn_i, .byte_i(par_out_o), .strobe_n_i(out_strobe_n_o),
      .ack_n_i(in_ack_n_o), .sel_i(unit_select_bit_o), .ien_n_i(in_enable_n_o), .delay_i(dly),
      .load_i(load), .next_i(nxt), .accept_n_o(output_accept_ready_n_i),
      .ready_n_o(input_byte_ready_n_i), .data_o(par_in_i), .got_o(got));
   always #4 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task give_verdict();
      $display("errors %0d of %0d compares", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   function logic [31:0] cexp(input logic [7:0] c);
      cexp = {24'h0, c[7:4], 1'h0, output_accept_ready_n_i, input_byte_ready_n_i, 1'h0};
   endfunction
   task automatic wt(ref logic s, input logic v);
      for (int k = 0; k < 99 && s !== v; k++) @(posedge clock_i);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
      bit done = 0;
      @(posedge clock_i);
      s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= v; s_axi_wstrb <= s;
      s_axi_wvalid <= 1; s_axi_bready <= 1;
      while (!done) begin
         @(posedge clock_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) begin r = s_axi_bresp; s_axi_bready <= 0; done = 1; end
      end
   endtask
   task automatic rd(input logic [31:0] a);
      bit done = 0;
      @(posedge clock_i);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      while (!done) begin
         @(posedge clock_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) begin d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0; done = 1; end
      end
   endtask
   task give_byte(input logic [7:0] c);
      @(posedge clock_i);
      load <= 1; nxt <= c;
      @(posedge clock_i);
      load <= 0;
      repeat (3) @(posedge clock_i);
   endtask
   initial begin
      repeat (10) @(posedge clock_i);
      rstn_i <= 1;
      rd(CTL); chk(d, cexp(8'h00));
      chk({unit_select_hi_o, unit_select_bit_o, in_enable_n_o, out_enable_n_o}, 4'b0011);
      wr(CTL, 32'hF0, 4'hF); chk(r, PDP_RESP_OKAY);
      wr(MSK, 32'h3, 4'hF); rd(STA); chk(d, 32'h1);
      chk({unit_select_hi_o, unit_select_bit_o, in_enable_n_o, out_enable_n_o}, 4'b1100);
      wr(CTL + 4, 32'h0, 4'hF); chk(r, PDP_RESP_SLVERR);
      rd(CTL + 4); chk(r, PDP_RESP_SLVERR);
      wr(CTL, 32'h0, 4'h0); rd(CTL); chk(d, cexp(8'hF0));
      repeat (6) begin
         b = 8'($random(seed));
         dly <= 4'($random(seed));
         wr(DAT, {24'h0, b}, 4'hF); chk(r, PDP_RESP_OKAY);
         wt(out_strobe_n_o, 0); chk(par_out_o, b);
         wt(output_accept_ready_n_i, 1); wt(output_accept_ready_n_i, 0);
         repeat (3) @(posedge clock_i);
         chk(irq_o, 1); chk(got, b);
         rd(STA); chk(d, 32'h1);
         repeat (2) @(posedge clock_i);
         chk(irq_o, 0);
         give_byte(8'($random(seed)));
         chk(irq_o, 1); rd(CTL); chk(d, cexp(8'hF0));
         rd(DAT); chk(d, {24'h0, nxt});
         wt(in_ack_n_o, 0); wt(in_ack_n_o, 1); chk(input_byte_ready_n_i, 1);
         rd(STA); chk(d, 32'h2);
      end
      wr(MSK, 32'h0, 4'hF); give_byte(8'hA5); chk(irq_o, 0);
      rd(STA); chk(d, 32'h2);
      give_verdict();
   end
endmodule // pdp_top_bench
`default_nettype wire
